// ===== rtl/cfg_lock_defines.svh
// Purpose: constants for the volatile configuration/lock register block
// Assumes: one 125 MHz clock, synchronous active-high reset
// Notes:   bit positions, command codes and register addresses live here
`ifndef CFG_LOCK_DEFINES_SVH
`define CFG_LOCK_DEFINES_SVH

`define CMD_LEGACY_WRITE   8'h01
`define CMD_CONFIG_READ    8'h35
`define CMD_ANY_READ       8'h65
`define CMD_ANY_WRITE      8'h71

`define BIT_ORIGIN         5
`define BIT_SOURCE         3
`define BIT_PARAM          2
`define BIT_WIDTH          1
`define BIT_LOCK           0
`define BIT_SWD            7
`define BIT_FOURWIDE       6
`define LVL_HI             4
`define LVL_LO             2

`define SYNC_STAGES        2
`define BYTE_BITS          4'h8

`define ADDR_NVSTA         8'h00
`define ADDR_NVCFG         8'h02
`define ADDR_VSTA          8'h80
`define ADDR_VCFG          8'h82
`define ADDR_NVIFC         8'h03
`define ADDR_VIFC          8'h83

`endif

// ===== rtl/cfg_lock_pkg.sv
// Purpose: types for the volatile configuration/lock register block
// Assumes: constants come from cfg_lock_defines.svh
// Notes:   none
package cfg_lock_pkg;
  typedef enum logic [4:0] {
    ST_IDLE = 5'b00001,
    ST_CMD  = 5'b00010,
    ST_ADDR = 5'b00100,
    ST_DATA = 5'b01000,
    ST_DONE = 5'b10000
  } frame_state_t;
endpackage : cfg_lock_pkg

// ===== rtl/edge_find.sv
// Purpose: rising and falling edge pulses of a synchronised level
// Assumes: input already synchronised to mclk
// Notes:   pulses last one mclk cycle
module edge_find (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic level,
  output logic      rise,
  output logic      fall
);
  logic last;
  always_ff @(posedge mclk)
  begin
    if (reset)
      last <= level;
    else
      last <= level;
  end
  assign rise = level & ~last;
  assign fall = ~level & last;
endmodule : edge_find

// ===== rtl/pin_sync.sv
// Purpose: two-flop synchroniser for one asynchronous level
// Assumes: mclk domain
// Notes:   the first flop feeds only the second
module pin_sync (
  input  wire logic mclk,
  input  wire logic reset,
  input  wire logic init,
  input  wire logic async_in,
  output logic      sync_out
);
  logic stage_one;
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      // reset to the pin's idle level so no false edge follows reset
      stage_one <= init;
      sync_out  <= init;
    end
    else
    begin
      stage_one <= async_in;
      sync_out  <= stage_one;
    end
  end
endmodule : pin_sync

// ===== rtl/volatile_config_lock_register.sv
// Purpose: volatile config register 1 with lane width and lock bit
// Assumes: serial mode 0 frames, command byte, 8-bit address for any-reg
// Notes:   the nv store is modelled by flops loaded from power-on straps
`include "cfg_lock_defines.svh"
module volatile_config_lock_register (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       power_on,
  input  wire logic       hw_reset_n,
  input  wire logic       sw_reset,
  input  wire logic [7:0] nonvolatile_config_one,
  input  wire logic [7:0] nonvolatile_status_one,
  input  wire logic       fourwide_nv_strap,
  input  wire logic       sclk,
  input  wire logic       cs_n,
  input  wire logic       si,
  input  wire logic       protect_pin,
  input  wire logic       otp_program_req,
  input  wire logic       otp_addr_in_area,
  output logic            so,
  output logic            so_oe,
  output logic [7:0]      volatile_config_one,
  output logic [7:0]      nv_config_one_out,
  output logic [7:0]      status_one_out,
  output logic            four_wide_instruction_protocol,
  output logic            four_lane,
  output logic            write_protect_active,
  output logic            lane3_is_data,
  output logic            otp_program_ok,
  output logic            program_error
);
  logic sclk_s, cs_n_s, si_s, wp_s, hwr_s;
  logic sclk_rise, sclk_fall, cs_rise, cs_fall;

  pin_sync u_sclk (.mclk(mclk), .reset(reset), .init(1'b0),
                   .async_in(sclk), .sync_out(sclk_s));
  pin_sync u_cs   (.mclk(mclk), .reset(reset), .init(1'b1),
                   .async_in(cs_n), .sync_out(cs_n_s));
  pin_sync u_si   (.mclk(mclk), .reset(reset), .init(1'b0),
                   .async_in(si), .sync_out(si_s));
  pin_sync u_wp   (.mclk(mclk), .reset(reset), .init(1'b0),
                   .async_in(protect_pin), .sync_out(wp_s));
  pin_sync u_hwr  (.mclk(mclk), .reset(reset), .init(1'b1),
                   .async_in(hw_reset_n), .sync_out(hwr_s));
  edge_find u_eck (.mclk(mclk), .reset(reset), .level(sclk_s),
                   .rise(sclk_rise), .fall(sclk_fall));
  edge_find u_ecs (.mclk(mclk), .reset(reset), .level(cs_n_s),
                   .rise(cs_rise), .fall(cs_fall));

  // hardware reset only counts while chip select is high
  logic hw_reset_evt;
  assign hw_reset_evt = ~hwr_s & cs_n_s;
  logic full_reload;
  assign full_reload = power_on | hw_reset_evt;

  // one-hot frame decoder
  cfg_lock_pkg::frame_state_t state, next_state;
  logic [7:0] shift, next_shift;
  logic [3:0] bits, next_bits;
  logic [7:0] cmd, next_cmd;
  logic [7:0] addr, next_addr;
  logic [7:0] wr0, next_wr0;
  logic [1:0] nbytes, next_nbytes;
  logic [7:0] rdval, next_rdval;
  logic       cmd_done, next_cmd_done;

  // register state
  logic [7:0] nvcfg, next_nvcfg;
  logic [7:0] nvsta, next_nvsta;
  logic [4:2] bpv, next_bpv;
  logic       width, next_width;
  logic       lock, next_lock;
  logic       cr2v6, next_cr2v6;
  logic       cr2nv6, next_cr2nv6;
  logic       perr, next_perr;
  logic       otp_ok, next_otp_ok;
  logic       so_q, next_so_q;

  function automatic logic [7:0] cfg1_view(input logic [7:0] nv,
                                           input logic w,
                                           input logic l);
    logic [7:0] v;
    v = 8'h00;
    v[`BIT_ORIGIN] = nv[`BIT_ORIGIN];
    v[`BIT_SOURCE] = nv[`BIT_SOURCE];
    v[`BIT_PARAM]  = nv[`BIT_PARAM];
    v[`BIT_WIDTH]  = w;
    v[`BIT_LOCK]   = l;
    return v;
  endfunction : cfg1_view

  function automatic logic [7:0] rd_any(input logic [7:0] a,
                                        input logic [7:0] c1,
                                        input logic [7:0] s1,
                                        input logic [7:0] s1v,
                                        input logic [7:0] c1v);
    case (a)
      `ADDR_NVCFG: return c1;
      `ADDR_NVSTA: return s1;
      `ADDR_VSTA:  return s1v;
      `ADDR_VCFG:  return c1v;
      default:     return 8'h00;
    endcase
  endfunction : rd_any

  logic [7:0] cfg1_now, sta1_now;
  assign cfg1_now = cfg1_view(nvcfg, width, lock);
  // power-on reads the image; a hardware reset reads the nv copy
  logic [7:0] nv_src;
  assign nv_src = power_on ? nonvolatile_config_one : nvcfg;
  always_comb
  begin
    sta1_now = 8'h00;
    sta1_now[`LVL_HI:`LVL_LO] = bpv;
  end

  always_comb
  begin
    next_state    = state;
    next_shift    = shift;
    next_bits     = bits;
    next_cmd      = cmd;
    next_addr     = addr;
    next_wr0      = wr0;
    next_nbytes   = nbytes;
    next_rdval    = rdval;
    next_cmd_done = 1'b0;
    next_so_q     = so_q;
    if (cs_rise)
    begin
      next_cmd_done = (state == cfg_lock_pkg::ST_DATA) && (nbytes != 2'd0);
      next_state    = cfg_lock_pkg::ST_IDLE;
    end
    else if (cs_fall)
    begin
      next_state  = cfg_lock_pkg::ST_CMD;
      next_bits   = 4'h0;
      next_nbytes = 2'd0;
    end
    else if (!cs_n_s && sclk_rise)
    begin
      next_shift = {shift[6:0], si_s};
      next_bits  = bits + 4'h1;
      if (bits + 4'h1 == `BYTE_BITS)
      begin
        next_bits = 4'h0;
        case (state)
          cfg_lock_pkg::ST_CMD:
          begin
            next_cmd = {shift[6:0], si_s};
            if ({shift[6:0], si_s} == `CMD_ANY_READ ||
                {shift[6:0], si_s} == `CMD_ANY_WRITE)
              next_state = cfg_lock_pkg::ST_ADDR;
            else
              next_state = cfg_lock_pkg::ST_DATA;
            next_rdval = cfg1_now;
          end
          cfg_lock_pkg::ST_ADDR:
          begin
            next_addr  = {shift[6:0], si_s};
            next_state = cfg_lock_pkg::ST_DATA;
            next_rdval = rd_any({shift[6:0], si_s}, nvcfg, nvsta,
                                sta1_now, cfg1_now);
          end
          cfg_lock_pkg::ST_DATA:
          begin
            if (nbytes == 2'd0)
              next_wr0 = {shift[6:0], si_s};
            if (nbytes != 2'd3)
              next_nbytes = nbytes + 2'd1;
            // second legacy byte targets config register one
            if (cmd == `CMD_LEGACY_WRITE && nbytes == 2'd1)
              next_addr = {shift[6:0], si_s};
            if (cmd == `CMD_CONFIG_READ)
              next_rdval = cfg1_now;
          end
          default: next_state = cfg_lock_pkg::ST_IDLE;
        endcase
      end
    end
    else if (!cs_n_s && sclk_fall && state == cfg_lock_pkg::ST_DATA)
    begin
      next_so_q  = rdval[7];
      next_rdval = {rdval[6:0], 1'b0};
    end
  end

  // write application on frame end; lock gating is per field
  always_comb
  begin
    next_nvcfg  = nvcfg;
    next_nvsta  = nvsta;
    next_bpv    = bpv;
    next_width  = width;
    next_lock   = lock;
    next_cr2v6  = cr2v6;
    next_cr2nv6 = cr2nv6;
    next_perr   = perr;
    next_otp_ok = 1'b0;
    next_nvcfg[7:6] = 2'b00;
    next_nvcfg[4]   = 1'b0;
    if (cmd_done && cmd == `CMD_LEGACY_WRITE)
    begin
      // status byte then config byte
      next_nvsta[`BIT_SWD] = wr0[`BIT_SWD];
      if (!lock)
      begin
        if (nvcfg[`BIT_SOURCE])
          next_bpv = wr0[`LVL_HI:`LVL_LO];
        else
        begin
          next_nvsta[`LVL_HI:`LVL_LO] = wr0[`LVL_HI:`LVL_LO];
          next_bpv = wr0[`LVL_HI:`LVL_LO];
        end
      end
      if (nbytes >= 2'd2)
      begin
        if (!lock)
        begin
          next_nvcfg[`BIT_ORIGIN] = nvcfg[`BIT_ORIGIN] | addr[`BIT_ORIGIN];
          next_nvcfg[`BIT_SOURCE] = nvcfg[`BIT_SOURCE] | addr[`BIT_SOURCE];
          next_nvcfg[`BIT_PARAM]  = nvcfg[`BIT_PARAM]  | addr[`BIT_PARAM];
        end
        if (!(cr2v6 && !addr[`BIT_WIDTH]))
        begin
          next_nvcfg[`BIT_WIDTH] = addr[`BIT_WIDTH];
          next_width             = addr[`BIT_WIDTH];
        end
        if (!lock)
          next_lock = addr[`BIT_LOCK];
      end
    end
    else if (cmd_done && cmd == `CMD_ANY_WRITE)
    begin
      case (addr)
        `ADDR_VCFG:
        begin
          if (!(cr2v6 && !wr0[`BIT_WIDTH]))
            next_width = wr0[`BIT_WIDTH];
          if (!lock)
            next_lock = wr0[`BIT_LOCK];
        end
        `ADDR_NVCFG:
        begin
          if (!lock)
          begin
            next_nvcfg[`BIT_ORIGIN] = nvcfg[`BIT_ORIGIN] | wr0[`BIT_ORIGIN];
            next_nvcfg[`BIT_SOURCE] = nvcfg[`BIT_SOURCE] | wr0[`BIT_SOURCE];
            next_nvcfg[`BIT_PARAM]  = nvcfg[`BIT_PARAM]  | wr0[`BIT_PARAM];
          end
          if (!(cr2v6 && !wr0[`BIT_WIDTH]))
            next_nvcfg[`BIT_WIDTH] = wr0[`BIT_WIDTH];
        end
        `ADDR_NVSTA:
        begin
          next_nvsta[`BIT_SWD] = wr0[`BIT_SWD];
          if (!lock)
            next_nvsta[`LVL_HI:`LVL_LO] = wr0[`LVL_HI:`LVL_LO];
        end
        `ADDR_VSTA:
        begin
          if (!lock)
            next_bpv = wr0[`LVL_HI:`LVL_LO];
        end
        `ADDR_VIFC:  next_cr2v6 = wr0[`BIT_FOURWIDE];
        `ADDR_NVIFC:
        begin
          if (wr0[`BIT_FOURWIDE])
          begin
            next_cr2nv6            = 1'b1;
            next_nvcfg[`BIT_WIDTH] = 1'b1;
          end
        end
        default: next_cr2nv6 = cr2nv6;
      endcase
    end
    if (otp_program_req && otp_addr_in_area)
    begin
      if (lock)
        next_perr = 1'b1;
      else
        next_otp_ok = 1'b1;
    end
    if (sw_reset)
    begin
      next_width = nvcfg[`BIT_WIDTH]; // lock untouched
      next_cr2v6 = cr2nv6;
    end
    if (full_reload)
    begin
      next_width = nv_src[`BIT_WIDTH];
      next_lock  = nv_src[`BIT_LOCK];
      next_cr2v6 = cr2nv6;
      next_perr  = 1'b0;
    end
    if (power_on)
    begin
      next_nvcfg = nonvolatile_config_one & 8'h2f;
      next_nvsta = nonvolatile_status_one;
      next_bpv   = nonvolatile_status_one[`LVL_HI:`LVL_LO];
      next_cr2nv6 = fourwide_nv_strap;
      next_cr2v6  = fourwide_nv_strap;
      if (fourwide_nv_strap)
        next_nvcfg[`BIT_WIDTH] = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      state    <= cfg_lock_pkg::ST_IDLE;
      shift    <= 8'h00;
      bits     <= 4'h0;
      cmd      <= 8'h00;
      addr     <= 8'h00;
      wr0      <= 8'h00;
      nbytes   <= 2'd0;
      rdval    <= 8'h00;
      cmd_done <= 1'b0;
      so_q     <= 1'b0;
      nvcfg    <= 8'h00;
      nvsta    <= 8'h00;
      bpv      <= 3'b000;
      width    <= 1'b0;
      lock     <= 1'b0;
      cr2v6    <= 1'b0;
      cr2nv6   <= 1'b0;
      perr     <= 1'b0;
      otp_ok   <= 1'b0;
    end
    else
    begin
      state    <= next_state;
      shift    <= next_shift;
      bits     <= next_bits;
      cmd      <= next_cmd;
      addr     <= next_addr;
      wr0      <= next_wr0;
      nbytes   <= next_nbytes;
      rdval    <= next_rdval;
      cmd_done <= next_cmd_done;
      so_q     <= next_so_q;
      nvcfg    <= next_nvcfg;
      nvsta    <= next_nvsta;
      bpv      <= next_bpv;
      width    <= next_width;
      lock     <= next_lock;
      cr2v6    <= next_cr2v6;
      cr2nv6   <= next_cr2nv6;
      perr     <= next_perr;
      otp_ok   <= next_otp_ok;
    end
  end

  // registered outputs
  logic rd_active;
  assign rd_active = (state == cfg_lock_pkg::ST_DATA) &&
                     (cmd == `CMD_CONFIG_READ || cmd == `CMD_ANY_READ);
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      so                             <= 1'b0;
      so_oe                          <= 1'b0;
      volatile_config_one            <= 8'h00;
      nv_config_one_out              <= 8'h00;
      status_one_out                 <= 8'h00;
      four_wide_instruction_protocol <= 1'b0;
      four_lane                      <= 1'b0;
      write_protect_active           <= 1'b0;
      lane3_is_data                  <= 1'b0;
      otp_program_ok                 <= 1'b0;
      program_error                  <= 1'b0;
    end
    else
    begin
      so                             <= next_so_q;
      so_oe                          <= rd_active & ~cs_n_s;
      volatile_config_one            <= cfg1_view(nvcfg, width, lock);
      nv_config_one_out              <= nvcfg;
      status_one_out                 <= {nvsta[7:5], bpv, nvsta[1:0]};
      four_wide_instruction_protocol <= cr2v6;
      four_lane                      <= width;
      // pin ignored, seen as inactive in four-lane width
      write_protect_active           <= ~width & ~wp_s;
      lane3_is_data                  <= width & ~cs_n_s;
      otp_program_ok                 <= otp_ok;
      program_error                  <= perr;
    end
  end

  property p_lock_sticky;
    @(posedge mclk) disable iff (reset)
      (lock && !full_reload) |=> lock;
  endproperty
  a_lock_sticky: assert property (p_lock_sticky)
    else $error("lock dropped without power or hardware reset");

  property p_wp_ignored;
    @(posedge mclk) disable iff (reset)
      width |=> !write_protect_active;
  endproperty
  a_wp_ignored: assert property (p_wp_ignored)
    else $error("protect pin active in four-lane width");

  property p_no_clear_width;
    @(posedge mclk) disable iff (reset)
      (cr2v6 && width && !full_reload && !sw_reset) |=> width;
  endproperty
  a_no_clear_width: assert property (p_no_clear_width)
    else $error("width cleared while four-wide protocol on");

  property p_otp_fail;
    @(posedge mclk) disable iff (reset)
      (lock && otp_program_req && otp_addr_in_area && !full_reload)
        |-> ##2 program_error;
  endproperty
  a_otp_fail: assert property (p_otp_fail)
    else $error("locked otp program did not raise error");

  property p_shadow;
    @(posedge mclk) disable iff (reset)
      ##1 (volatile_config_one[5:2] == $past(nvcfg[5:2]) &&
           volatile_config_one[7:6] == 2'b00 &&
           volatile_config_one[4] == 1'b0);
  endproperty
  a_shadow: assert property (p_shadow)
    else $error("shadow or reserved bits wrong");

  property p_bp_frozen;
    @(posedge mclk) disable iff (reset)
      (lock && !power_on) |=> $stable(bpv);
  endproperty
  a_bp_frozen: assert property (p_bp_frozen)
    else $error("protection level changed while locked");

  property p_otp_bits_frozen;
    @(posedge mclk) disable iff (reset)
      (lock && !power_on) |=> $stable(nvcfg[5:2]);
  endproperty
  a_otp_bits_frozen: assert property (p_otp_bits_frozen)
    else $error("otp config bits changed while locked");

  property p_nv_fourwide;
    @(posedge mclk) disable iff (reset)
      cr2nv6 |-> nvcfg[1];
  endproperty
  a_nv_fourwide: assert property (p_nv_fourwide)
    else $error("nv width default clear with four-wide nv set");
endmodule : volatile_config_lock_register

// ===== tb/spi_host.sv
// Purpose: host controller model issuing single-lane register frames
// Assumes: mode 0, sclk idle low, 160 ns sclk period from an 8 ns mclk
// Notes:   si shows the inverse of its last bit once a frame ends
module spi_host (
  input  wire logic       mclk,
  input  wire logic       so,
  output logic            sclk,
  output logic            cs_n,
  output logic            si,
  output logic            done,
  output logic [7:0]      rd_byte
);
  timeunit 1ns;
  timeprecision 1ps;

  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    si = 1'b0;
    done = 1'b0;
    rd_byte = 8'h00;
  end

  // kind 0 writes; 1 returns the byte after cmd and address, 2 after cmd
  task automatic xfer(input logic [23:0] tx, input int kind);
    logic [23:0] rx;
    rx = 24'h000000;
    @(negedge mclk);
    cs_n = 1'b0;
    for (int i = 23; i >= 0; i--)
    begin
      // single-lane only, so the width bit need not be set first
      si = tx[i];
      repeat (10) @(negedge mclk);
      sclk = 1'b1;
      rx = {rx[22:0], so};
      repeat (10) @(negedge mclk);
      sclk = 1'b0;
    end
    repeat (3) @(negedge mclk);
    cs_n = 1'b1;
    si = ~si;
    repeat (12) @(negedge mclk);
    if (kind != 0)
    begin
      rd_byte = (kind == 1) ? rx[7:0] : rx[15:8];
      done = 1'b1;
      @(negedge mclk);
      done = 1'b0;
    end
  endtask : xfer
endmodule : spi_host

// ===== tb/testbench.sv
// Purpose: self-checking bench for the volatile config/lock register
// Assumes: frames come from spi_host; straps change only at boot
// Notes:   serial reads are matched against a queue of notes
`include "cfg_lock_defines.svh"
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        mclk, reset, power_on, hw_reset_n, sw_reset, protect_pin;
  logic        sclk, cs_n, si, so, done, otp_req, fw, ql, wp, l3, ok, perr;
  logic [7:0]  nv_cfg, rd_byte, vc1, nvc;
  logic [31:0] seed;
  int          fail_count, n_tests, cycles;
  logic [7:0]  exp_q[$], mask_q[$];

  volatile_config_lock_register DUT (
    .mclk,
    .reset,
    .power_on,
    .hw_reset_n,
    .sw_reset,
    .nonvolatile_config_one(nv_cfg),
    .nonvolatile_status_one(8'h00),
    .fourwide_nv_strap(1'b0),
    .sclk,
    .cs_n,
    .si,
    .protect_pin,
    .otp_program_req(otp_req),
    .otp_addr_in_area(1'b1),
    .so,
    .so_oe(),
    .volatile_config_one(vc1),
    .nv_config_one_out(nvc),
    .status_one_out(),
    .four_wide_instruction_protocol(fw),
    .four_lane(ql),
    .write_protect_active(wp),
    .lane3_is_data(l3),
    .otp_program_ok(ok),
    .program_error(perr)
  );

  spi_host host (
    .mclk,
    .so,
    .sclk,
    .cs_n,
    .si,
    .done,
    .rd_byte
  );

  initial
  begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  function automatic logic [31:0] xorshift(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xorshift

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic flag(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask : flag

  task automatic results;
    if (fail_count == 0 && n_tests > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  task automatic tick(input int n);
    repeat (n) @(negedge mclk);
  endtask : tick

  task automatic wr(input logic [7:0] addr, input logic [7:0] data);
    host.xfer({`CMD_ANY_WRITE, addr, data}, 0);
  endtask : wr

  task automatic rd(input logic [7:0] cmd, input logic [7:0] addr,
                    input logic [7:0] mask, input logic [7:0] exp);
    exp_q.push_back(exp);
    mask_q.push_back(mask);
    host.xfer({cmd, addr, 8'h00}, (cmd == `CMD_CONFIG_READ) ? 2 : 1);
  endtask : rd

  // power-on reload of the nv image; lock and width come from it
  task automatic boot(input logic [7:0] cfg);
    nv_cfg = cfg;
    power_on = 1'b1;
    tick(1);
    power_on = 1'b0;
    tick(6);
  endtask : boot

  task automatic wp_loop(input logic width);
    repeat (4)
    begin
      seed = xorshift(seed);
      protect_pin = seed[0];
      tick(6);
      flag(ql, width);
      flag(wp, ~width & ~seed[0]);
      flag(l3, 1'b0);
    end
  endtask : wp_loop

  task automatic otp(input logic exp_ok);
    logic seen;
    seen = 1'b0;
    otp_req = 1'b1;
    tick(1);
    otp_req = 1'b0;
    repeat (8)
    begin
      tick(1);
      if (ok === 1'b1)
        seen = 1'b1;
    end
    flag(seen, exp_ok);
    flag(perr, ~exp_ok);
  endtask : otp

  always @(posedge done)
  begin
    if (exp_q.size() > 0)
      check(rd_byte & mask_q.pop_front(), exp_q.pop_front());
    else
      check(8'h00, 8'hff);
  end

  // lane 3 carries data only while a frame is open in four-lane width
  always @(negedge sclk)
  begin
    if (cs_n === 1'b0)
      flag(l3, ql);
  end

  // a hang is caught at mclk cycle 40000, roughly three times the length of a full run
  always @(posedge mclk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      fail_count++;
      results();
    end
  end

  initial
  begin
    {reset, power_on, hw_reset_n, sw_reset} = 4'b1010;
    {protect_pin, otp_req, nv_cfg} = 10'h000;
    seed = 32'h2a31;
    {fail_count, n_tests, cycles} = {32'd0, 32'd0, 32'd0};
    tick(8);
    reset = 1'b0;
    tick(1);
    boot(8'h02);
    check(vc1, 8'h02);
    rd(`CMD_CONFIG_READ, 8'h00, 8'hff, 8'h02);
    rd(`CMD_ANY_READ, `ADDR_VCFG, 8'hff, 8'h02);
    wp_loop(1'b1);
    wr(`ADDR_VCFG, 8'h00);
    wp_loop(1'b0);
    seed = xorshift(seed);
    wr(`ADDR_VCFG, seed[7:0] & 8'hfe);
    check(vc1, seed[7:0] & 8'h02);
    rd(`CMD_ANY_READ, `ADDR_VCFG, 8'hff, seed[7:0] & 8'h02);
    wr(`ADDR_VCFG, 8'h02);
    wr(`ADDR_NVCFG, 8'h2a);
    check(vc1, 8'h2a);
    wr(`ADDR_VIFC, 8'h40);
    flag(fw, 1'b1);
    wr(`ADDR_VCFG, 8'h00);
    check(vc1, 8'h2a);
    wr(`ADDR_VIFC, 8'h00);
    wr(`ADDR_VCFG, 8'h00);
    check(vc1, 8'h28);
    for (int w = 0; w < 2; w++)
    begin
      host.xfer({`CMD_LEGACY_WRITE, 8'h00, 6'h00, w[0], 1'b0}, 0);
      flag(nvc[1], w[0]);
      check(vc1, {6'h0a, w[0], 1'b0});
    end
    otp(1'b1);
    wr(`ADDR_VSTA, 8'h1c);
    rd(`CMD_ANY_READ, `ADDR_VSTA, 8'h1c, 8'h1c);
    wr(`ADDR_VCFG, 8'h03);
    check(vc1, 8'h2b);
    wr(`ADDR_VSTA, 8'h00);
    rd(`CMD_ANY_READ, `ADDR_VSTA, 8'h1c, 8'h1c);
    wr(`ADDR_NVCFG, 8'h2e);
    check(vc1, 8'h2b);
    flag(perr, 1'b0);
    wr(`ADDR_VCFG, 8'h00);
    check(vc1, 8'h29);
    wr(`ADDR_NVSTA, 8'h80);
    rd(`CMD_ANY_READ, `ADDR_NVSTA, 8'h80, 8'h80);
    otp(1'b0);
    sw_reset = 1'b1;
    tick(1);
    sw_reset = 1'b0;
    tick(6);
    check(vc1, 8'h2b);
    hw_reset_n = 1'b0;
    tick(6);
    hw_reset_n = 1'b1;
    tick(8);
    check(vc1, 8'h2a);
    flag(perr, 1'b0);
    boot(8'h01);
    check(vc1, 8'h01);
    wr(`ADDR_VCFG, 8'h00);
    check(vc1, 8'h01);
    wr(`ADDR_NVIFC, 8'h40);
    flag(nvc[1], 1'b1);
    tick(4);
    results();
  end
endmodule : testbench
